// File: hdl/output_pulse_shaper_phase_step.sv
// Output stage: integer divider, pulse width shaper, coarse edge shifter and buffer mode select
`timescale 1ns/100ps

module output_pulse_shaper_phase_step
(
	// Clock and reset (ref_clk is the fractional divider clock)
	input  wire logic                                    ref_clk,
	input  wire logic                                    rst_n,
	// Classic Wishbone slave
	input  wire logic                                    wb_cyc_i,
	input  wire logic                                    wb_stb_i,
	input  wire logic                                    wb_we_i,
	input  wire logic [output_shaper_pkg::ADDR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]                              wb_sel_i,
	input  wire logic [31:0]                             wb_dat_i,
	output      logic [31:0]                             wb_dat_o,
	output      logic                                    wb_ack_o,
	// Output buffer
	output      logic                                    truePin,
	output      logic                                    complementPin,
	output      logic                                    singleEndedMode,
	output      logic [1:0]                              swingSelect,
	output      logic [1:0]                              impedanceSelect
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Merge a bus write into a register under the byte enables
	// Partial writes let software touch one byte of a wide count without reading it first
	function automatic logic [31:0] byteMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
		input logic [3:0] sel);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				res[i*8 +: 8] = newVal[i*8 +: 8];
		end
		return res;
	endfunction : byteMerge

	// Address compare shared by every register select
	function automatic logic addrHit(input logic [output_shaper_pkg::ADDR_W-1:0] adr,
		input logic [output_shaper_pkg::ADDR_W-1:0] ofs);
		return (adr == ofs);
	endfunction : addrHit

	// Place one status flag at its bit position in the status word
	function automatic logic [31:0] placeBit(input logic flag, input int pos);
		return 32'(flag) << pos;
	endfunction : placeBit

	// Step a half-period count down by one divider clock
	function automatic logic [33:0] countDown(input logic [33:0] count);
		return count - output_shaper_pkg::LAST_COUNT;
	endfunction : countDown

	// Plan one output period from the ratio, width and an optional signed shift.
	// Arithmetic is 35-bit signed so a full 32-bit shift on a full 32-bit half cannot wrap.
	function automatic output_shaper_pkg::period_t planPeriod(input logic [31:0] ratio,
		input logic [31:0] width, input logic signed [31:0] adj, input logic apply);
		logic signed [34:0]          r;
		logic signed [34:0]          w;
		logic signed [34:0]          a;
		logic signed [34:0]          ah;
		logic signed [34:0]          h;
		logic signed [34:0]          l;
		output_shaper_pkg::period_t  p;
		// Ratios below two cannot be made from a synchronous counter; run them as two
		r  = (ratio < output_shaper_pkg::MIN_RATIO) ? 35'(output_shaper_pkg::MIN_RATIO) : 35'(ratio);
		w  = 35'(width);
		a  = apply ? 35'(adj) : 35'sh0;
		ah = a >>> 1;
		// A custom width keeps its high pulse; only the low part takes the shift
		if (width != output_shaper_pkg::WIDTH_DEFAULT)
		begin
			h = w;
			l = (width >= ratio) ? output_shaper_pkg::ONE_PART : r - w;
			l = l + a;
		end
		else
		begin
			// Odd ratios give the extra cycle to the high half
			h = r - (r >>> 1) + ah;
			l = (r >>> 1) + (a - ah);
			if (apply && (h < output_shaper_pkg::MIN_PART))
				h = output_shaper_pkg::MIN_PART;
		end
		// A shortened half is held at two cycles so a receiver never sees a runt
		if (apply && (l < output_shaper_pkg::MIN_PART))
			l = output_shaper_pkg::MIN_PART;
		p.highLen = h[33:0];
		p.lowLen  = l[33:0];
		return p;
	endfunction : planPeriod

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	// Configuration registers
	logic [31:0]                 divRatio;
	logic [31:0]                 highWidth;
	logic signed [31:0]          edgeShift;
	output_shaper_pkg::ctrl_t    ctrl;
	// Shift request bookkeeping
	logic                        shiftPending;
	logic                        shiftRejected;
	// Sequencer state; remain counts the cycles left in the current half
	output_shaper_pkg::phase_t   phase;
	output_shaper_pkg::phase_t   next_phase;
	logic [33:0]                 remain;
	logic [33:0]                 next_remain;
	logic [33:0]                 lowLen;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------

	// A request is answered one cycle after it appears; writes land on the ack edge
	wire         busReq       = wb_cyc_i & wb_stb_i;
	wire         busWrite     = busReq & wb_we_i & wb_ack_o;
	// Unmapped addresses still get an ack, so a stray access cannot hang the bus
	wire         hitRatio     = addrHit(wb_adr_i, output_shaper_pkg::OFS_DIV_RATIO);
	wire         hitWidth     = addrHit(wb_adr_i, output_shaper_pkg::OFS_HIGH_WIDTH);
	wire         hitShift     = addrHit(wb_adr_i, output_shaper_pkg::OFS_EDGE_SHIFT);
	wire         hitCtrl      = addrHit(wb_adr_i, output_shaper_pkg::OFS_CTRL);
	wire         hitStatus    = addrHit(wb_adr_i, output_shaper_pkg::OFS_STATUS);
	wire         hitCount     = addrHit(wb_adr_i, output_shaper_pkg::OFS_PHASE_COUNT);
	wire         shiftWrite   = busWrite & hitShift;

	// Coarse shifting is refused on ratios of four and below
	wire         shiftBlocked = (divRatio < output_shaper_pkg::MIN_RATIO_SHIFT);

	// Status word built from live state; pending and rejected let software pace its shifts
	wire [31:0]  statusWord   = placeBit(shiftPending, output_shaper_pkg::STAT_PENDING)
	                          | placeBit(shiftRejected, output_shaper_pkg::STAT_REJECTED)
	                          | placeBit(truePin, output_shaper_pkg::STAT_LEVEL)
	                          | placeBit(shiftBlocked, output_shaper_pkg::STAT_BLOCKED)
	                          | placeBit(phase != output_shaper_pkg::PH_IDLE, output_shaper_pkg::STAT_RUNNING);

	// Read multiplexer; unmapped addresses read as zero
	wire [31:0]  readData     = hitRatio  ? divRatio
	                          : hitWidth  ? highWidth
	                          : hitShift  ? edgeShift
	                          : hitCtrl   ? 32'(ctrl)
	                          : hitStatus ? statusWord
	                          : hitCount  ? remain[31:0]
	                          : 32'h0000_0000;

	// ------------------------------------------------------------
	// Period sequencing
	// ------------------------------------------------------------

	// Last cycle of a half; a zero count ends the half too, so a stale count cannot stall
	wire         lastCycle    = (remain <= output_shaper_pkg::LAST_COUNT);
	// A period starts from idle or after the last low cycle, and only while enabled
	wire         periodStart  = ctrl.enable & ((phase == output_shaper_pkg::PH_IDLE) |
	                                           ((phase == output_shaper_pkg::PH_LOW) & lastCycle));
	wire         applyShift   = periodStart & shiftPending & ~shiftBlocked;
	wire         rejectShift  = periodStart & shiftPending & shiftBlocked;
	// Width, ratio and shift are sampled only here, so a mid-period write never makes a runt
	wire output_shaper_pkg::period_t plan = planPeriod(divRatio, highWidth, edgeShift, applyShift);

	// Next phase and count; the high half is never cut short, even by a disable
	always_comb
	begin
		next_phase  = phase;
		next_remain = remain;
		unique case (phase)
			output_shaper_pkg::PH_IDLE:
			begin
				// Idle until enabled; the first period is planned from the live settings
				if (periodStart)
				begin
					next_phase  = output_shaper_pkg::PH_HIGH;
					next_remain = plan.highLen;
				end
			end
			output_shaper_pkg::PH_HIGH:
			begin
				if (lastCycle)
				begin
					next_phase  = output_shaper_pkg::PH_LOW;
					next_remain = lowLen;
				end
				else
					next_remain = countDown(remain);
			end
			output_shaper_pkg::PH_LOW:
			begin
				// Trade-off: a disable waits for the end of the low half rather than cut a pulse
				if (periodStart)
				begin
					next_phase  = output_shaper_pkg::PH_HIGH;
					next_remain = plan.highLen;
				end
				else if (lastCycle)
				begin
					next_phase  = output_shaper_pkg::PH_IDLE;
					next_remain = 34'h0;
				end
				else
					next_remain = countDown(remain);
			end
			default:
			begin
				next_phase  = output_shaper_pkg::PH_IDLE;
				next_remain = 34'h0;
			end
		endcase
	end

	// Level the pins will show next: high only in the high half
	wire         next_level   = (next_phase == output_shaper_pkg::PH_HIGH);
	// Differential drives the opposite level; single-ended copies, optionally inverted
	wire         next_comp    = ctrl.singleEnded ? (next_level ^ ctrl.complementInvert)
	                                             : ~next_level;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------

	// Ack pulses for one cycle; read data is captured with it
	// Ack falls in the cycle after it rises, so a held request is answered only every other cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= busReq & ~wb_ack_o;
			wb_dat_o <= (busReq & ~wb_ack_o) ? readData : wb_dat_o;
		end
	end

	// Software-written configuration
	// Status and phase count are read-only; writes to them fall through
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			divRatio  <= output_shaper_pkg::DIV_RATIO_RST;
			highWidth <= output_shaper_pkg::HIGH_WIDTH_RST;
			edgeShift <= output_shaper_pkg::EDGE_SHIFT_RST;
			ctrl      <= output_shaper_pkg::CTRL_RST;
		end
		else
		begin
			if (busWrite & hitRatio)
				divRatio <= byteMerge(divRatio, wb_dat_i, wb_sel_i);
			if (busWrite & hitWidth)
				highWidth <= byteMerge(highWidth, wb_dat_i, wb_sel_i);
			if (shiftWrite)
				edgeShift <= byteMerge(edgeShift, wb_dat_i, wb_sel_i);
			if (busWrite & hitCtrl)
				ctrl <= 7'(byteMerge(32'(ctrl), wb_dat_i, wb_sel_i));
		end
	end

	// Shift request flags; a new write wins over consumption in the same cycle
	// A refused shift stays flagged until software writes a new shift value
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			shiftPending  <= 1'b0;
			shiftRejected <= 1'b0;
		end
		else
		begin
			shiftPending  <= shiftWrite | (shiftPending & ~periodStart);
			shiftRejected <= rejectShift | (shiftRejected & ~shiftWrite);
		end
	end

	// ------------------------------------------------------------
	// Sequencer and pins
	// ------------------------------------------------------------

	// Phase counter; low length is latched at the period start with the high length
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			phase  <= output_shaper_pkg::PH_IDLE;
			remain <= 34'h0;
			lowLen <= 34'h0;
		end
		else
		begin
			phase  <= next_phase;
			remain <= next_remain;
			lowLen <= periodStart ? plan.lowLen : lowLen;
		end
	end

	// Pins and buffer settings all leave from flip-flops
	// Buffer settings move one cycle after the control write, together with the pins
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			truePin         <= 1'b0;
			complementPin   <= 1'b1;
			singleEndedMode <= 1'b0;
			swingSelect     <= 2'h0;
			impedanceSelect <= 2'h0;
		end
		else
		begin
			truePin         <= next_level;
			complementPin   <= next_comp;
			singleEndedMode <= ctrl.singleEnded;
			swingSelect     <= ctrl.swingSelect;
			impedanceSelect <= ctrl.impedanceSelect;
		end
	end

endmodule : output_pulse_shaper_phase_step

// File: hdl/output_shaper_pkg.sv
// Shared constants and types for the output pulse shaper and coarse edge shifter
package output_shaper_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam int          ADDR_W           = 8;
	localparam logic [7:0]  OFS_DIV_RATIO    = 8'h00;
	localparam logic [7:0]  OFS_HIGH_WIDTH   = 8'h04;
	localparam logic [7:0]  OFS_EDGE_SHIFT   = 8'h08;
	localparam logic [7:0]  OFS_CTRL         = 8'h0C;
	localparam logic [7:0]  OFS_STATUS       = 8'h10;
	localparam logic [7:0]  OFS_PHASE_COUNT  = 8'h14;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] DIV_RATIO_RST    = 32'h0000_0002;
	localparam logic [31:0] HIGH_WIDTH_RST   = 32'h0000_0000;
	localparam logic [31:0] EDGE_SHIFT_RST   = 32'h0000_0000;
	localparam logic [6:0]  CTRL_RST         = 7'h00;

	// ------------------------------------------------------------
	// Divider limits
	// ------------------------------------------------------------
	localparam logic [31:0]        MIN_RATIO       = 32'h0000_0002;
	localparam logic [31:0]        MIN_RATIO_SHIFT = 32'h0000_0005;
	localparam logic [31:0]        WIDTH_DEFAULT   = 32'h0000_0000;
	localparam logic signed [34:0] MIN_PART        = 35'sh2;
	localparam logic signed [34:0] ONE_PART        = 35'sh1;
	localparam logic [33:0]        LAST_COUNT      = 34'h1;

	// ------------------------------------------------------------
	// Status bit positions
	// ------------------------------------------------------------
	localparam int STAT_PENDING  = 0;
	localparam int STAT_REJECTED = 1;
	localparam int STAT_LEVEL    = 2;
	localparam int STAT_BLOCKED  = 3;
	localparam int STAT_RUNNING  = 4;

	// Control word: bit0 enable, bit1 single-ended, bit2 invert, [4:3] swing, [6:5] impedance
	typedef struct packed {
		logic [1:0] impedanceSelect;
		logic [1:0] swingSelect;
		logic       complementInvert;
		logic       singleEnded;
		logic       enable;
	} ctrl_t;

	// Lengths of the two halves of one output period, in divider clocks
	typedef struct packed {
		logic [33:0] highLen;
		logic [33:0] lowLen;
	} period_t;

	// Output phase sequencer
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_HIGH = 3'b010,
		PH_LOW  = 3'b100
	} phase_t;

endpackage : output_shaper_pkg

// File: tb/output_shaper_checker.sv
// Port-level checks for the output pulse shaper
`timescale 1ns/100ps

module output_shaper_checker
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Register bus
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// Output buffer
	input wire logic       truePin,
	input wire logic       complementPin,
	input wire logic       singleEndedMode,
	input wire logic [1:0] swingSelect,
	input wire logic [1:0] impedanceSelect
);
	// ----------------------------------------
	// Properties, all in the one clock domain
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack held longer than one cycle");
	property p_ackAnswer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ackAnswer: assert property (p_ackAnswer) else $error("request not answered in one cycle");
	property p_ackCause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ackCause: assert property (p_ackCause) else $error("ack without a request");
	// Differential pair is always complementary
	property p_diffPair; !singleEndedMode |-> complementPin == !truePin; endproperty
	a_diffPair: assert property (p_diffPair) else $error("pins not complementary");
	// Copies toggle together unless a bus access was acked in the last two cycles
	property p_copyToggle;
		singleEndedMode && $changed(truePin) && !$past(wb_ack_o) && !$past(wb_ack_o, 2) |-> $changed(complementPin);
	endproperty
	a_copyToggle: assert property (p_copyToggle) else $error("copy did not follow true pin");
	property p_swingHold; $changed(swingSelect) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
	a_swingHold: assert property (p_swingHold) else $error("swing changed without a write");
	property p_impHold; $changed(impedanceSelect) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
	a_impHold: assert property (p_impHold) else $error("impedance changed without a write");
	property p_modeHold; $changed(singleEndedMode) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
	a_modeHold: assert property (p_modeHold) else $error("buffer mode changed without a write");

	// Main scenarios reached
	c_access: cover property (wb_ack_o);
	c_singleRun: cover property (singleEndedMode && $rose(truePin));
	c_diffRun: cover property (!singleEndedMode && $rose(truePin));
endmodule : output_shaper_checker

bind output_pulse_shaper_phase_step output_shaper_checker chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .truePin(truePin),
	.complementPin(complementPin), .singleEndedMode(singleEndedMode), .swingSelect(swingSelect),
	.impedanceSelect(impedanceSelect));

// File: tb/clock_receiver_model.sv
// Downstream receiver model that times each output period
`timescale 1ns/100ps

module clock_receiver_model
(
	// Clock and watched pin
	input  wire logic ref_clk,
	input  wire logic truePin,
	// Last complete period in divider clocks
	output logic      periodDone,
	output int        measHigh,
	output int        measLow
);
	logic prev = 1'b0;
	int   hCnt = 0;
	int   lCnt = 0;

	// A rise closes the period before it; idle low before the first rise is not a period
	always @(posedge ref_clk)
	begin
		periodDone <= truePin && !prev && lCnt > 0;
		if (truePin && !prev)
		begin
			measHigh <= hCnt;
			measLow  <= lCnt;
			hCnt = 1;
			lCnt = 0;
		end
		else if (truePin)
			hCnt++;
		else if (hCnt > 0)
			lCnt++;
		prev = truePin;
	end
endmodule : clock_receiver_model

// File: tb/output_pulse_shaper_phase_step_tb.sv
// Self-checking bench for the output pulse shaper
`timescale 1ns/100ps

module output_pulse_shaper_phase_step_tb;
	// ----------------------------------------
	// Signals, tables and bench model
	// ----------------------------------------
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF, byteEn = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd, ctl;
	logic        wb_ack_o, truePin, complementPin, singleEndedMode, periodDone;
	logic [1:0]  swingSelect, impedanceSelect;
	int          measHigh, measLow, h, l, eh, el, failures = 0, tests_run = 0;
	int          seed = 32'h296F;
	logic [7:0]  adrs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
	logic [31:0] rstv [5] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
	int          divs [4] = '{2, 3, 7, 10};
	int          wids [4] = '{0, 0, 0, 3};
	int          sR [6] = '{8, 8, 8, 12, 12, 4};
	int          sW [6] = '{0, 0, 0, 5, 5, 0};
	int          sS [6] = '{5, -3, -100, 6, -9, 6};

	always #25 ref_clk = ~ref_clk;

	output_pulse_shaper_phase_step DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .truePin(truePin), .complementPin(complementPin),
		.singleEndedMode(singleEndedMode), .swingSelect(swingSelect), .impedanceSelect(impedanceSelect));
	clock_receiver_model rx (.ref_clk(ref_clk), .truePin(truePin), .periodDone(periodDone),
		.measHigh(measHigh), .measLow(measLow));

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// One classic cycle; entered just after an edge, holds until ack is sampled
	task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= byteEn;
		wb_dat_i <= dat;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			failures++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : wbCycle

	task automatic getPeriod();
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (periodDone !== 1'b1 && n < 400);
		if (n >= 400)
			failures++;
		h = measHigh;
		l = measLow;
	endtask : getPeriod

	// Expected halves; a shift is clipped to two cycles a half and refused below ratio five
	task automatic measure(input int r, input int w, input int s);
		getPeriod();
		eh = (w == 0) ? r - r / 2 : w;
		el = (w == 0) ? r / 2 : r - w;
		if (s != 0 && r >= 5)
		begin
			eh = (w == 0) ? eh + (s >>> 1) : eh;
			el = (w == 0) ? el + s - (s >>> 1) : el + s;
			eh = (w == 0 && eh < 2) ? 2 : eh;
			el = (el < 2) ? 2 : el;
		end
		check(32'(h), 32'(eh));
		check(32'(l), 32'(el));
	endtask : measure

	// New settings land at a period start, so two periods are let pass
	task automatic setCfg(input int r, input int w);
		wbCycle(1'b1, output_shaper_pkg::OFS_DIV_RATIO, 32'(r));
		wbCycle(1'b1, output_shaper_pkg::OFS_HIGH_WIDTH, 32'(w));
		getPeriod();
		getPeriod();
	endtask : setCfg

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// Watchdog well beyond the expected run
	initial
	begin
		#(50 * 20000);
		failures++;
		print_verdict();
	end

	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		wbCycle(1'b1, 8'h20, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++)
		begin
			wbCycle(1'b0, adrs[i], 32'h0);
			check(rd, rstv[i]);
		end
		// Byte enables: only the middle two bytes land; the request is refused later at ratio two
		byteEn = 4'h6;
		wbCycle(1'b1, output_shaper_pkg::OFS_EDGE_SHIFT, 32'h1234_5678);
		byteEn = 4'hF;
		wbCycle(1'b0, output_shaper_pkg::OFS_EDGE_SHIFT, 32'h0);
		check(rd, 32'h0034_5600);
		wbCycle(1'b1, output_shaper_pkg::OFS_CTRL, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			setCfg(divs[i], wids[i]);
			measure(divs[i], wids[i], 0);
			measure(divs[i], wids[i], 0);
		end
		// Shift written just after a period start: that period plain, the next shifted (refused at ratio four, so plain), then plain
		for (int i = 0; i < 6; i++)
		begin
			setCfg(sR[i], sW[i]);
			getPeriod();
			wbCycle(1'b1, output_shaper_pkg::OFS_EDGE_SHIFT, 32'(sS[i]));
			wbCycle(1'b0, output_shaper_pkg::OFS_STATUS, 32'h0);
			check(32'(rd[output_shaper_pkg::STAT_PENDING]), 32'h1);
			measure(sR[i], sW[i], 0);
			measure(sR[i], sW[i], sS[i]);
			measure(sR[i], sW[i], 0);
			wbCycle(1'b0, output_shaper_pkg::OFS_STATUS, 32'h0);
			check(32'(rd[output_shaper_pkg::STAT_REJECTED]), 32'(sR[i] < 5));
			check(32'(rd[output_shaper_pkg::STAT_BLOCKED]), 32'(sR[i] < 5));
			check(32'(rd[output_shaper_pkg::STAT_RUNNING]), 32'h1);
		end
		// Buffer modes with every swing code and random impedance
		for (int i = 0; i < 4; i++)
		begin
			ctl = {25'h0, 2'($random(seed)), 2'(i), i[0], i != 0, 1'b1};
			wbCycle(1'b1, output_shaper_pkg::OFS_CTRL, ctl);
			wbCycle(1'b0, output_shaper_pkg::OFS_CTRL, 32'h0);
			check(rd, ctl);
			repeat (4)
			begin
				@(posedge ref_clk);
				check(32'({singleEndedMode, swingSelect, impedanceSelect}), 32'({ctl[1], ctl[4:3], ctl[6:5]}));
				check(32'(complementPin), 32'(ctl[1] ? truePin ^ ctl[2] : !truePin));
			end
		end
		print_verdict();
	end
endmodule : output_pulse_shaper_phase_step_tb
